// file: hdl/avrsc_route_ctrl.sv
// four-in two-out audio/video route control with avalon-mm registers
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// (R01) video selections pass only while video apply high
// (R02) audio selections pass only while audio apply high
// (R03) inhibit blocks panel entry into local mode
// (R04) inhibited panel may view, never change routes
// (R05) inhibit forces local mode back to system
// (R06) system mode routes follow control system selections
// (R07) video code 0 mutes, 1-4 pick input
// (R08) audio code 0 mutes, 1-4 pick input
// (R09) separate selections per output, only 0-4 accepted
// (R10) panel mode flag high exactly in local mode
// (R11) route reports always show active sources
// (R12) reports use the same encoding as selections
// (R13) text commands change routes or query status
// (R14) verbose mode reports every route change unsolicited
// (R15) query returns full routing state on feedback
// (R16) controller uses text or selections, not both
// (R17) controller addresses device by matching node number; no node number here, the bus address picks a register
// (R18) apply low holds routes, release applies latest
module avrsc_route_ctrl
  import avrsc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  input  wire logic        panel_local_btn_i,
  input  wire logic        panel_route_take_i,
  input  wire logic [11:0] panel_route_i,
  output logic             panel_mode_flag_o,
  output logic [2:0]       video_dest_one_report_o,
  output logic [2:0]       video_dest_two_report_o,
  output logic [2:0]       audio_dest_one_report_o,
  output logic [2:0]       audio_dest_two_report_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] pick_src(input logic [2:0] cand,
                                          input logic [2:0] keep);
    pick_src = (cand <= SRC_MAX) ? cand : keep;
  endfunction

  function automatic logic [7:0] src_char(input logic [2:0] code);
    src_char = ASC_ZERO + {5'h00, code};
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  avrsc_ctrl_t   ctrl_ff;
  avrsc_routes_t sel_ff;
  avrsc_routes_t routes_ff;
  avrsc_routes_t nxt_routes;
  avrsc_routes_t panel_routes;
  avrsc_routes_t rep_snap_ff;
  avrsc_cmd_st_t cmd_st_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] irq_evt;
  logic [13:0]   pin_level;
  logic          btn_prev_ff;
  logic          take_prev_ff;
  logic          btn_press;
  logic          take_press;
  logic          local_ff;
  logic          nxt_local;
  logic          wr_acc;
  logic          rd_acc;
  logic          cmd_wr;
  logic          fb_pop;
  logic [7:0]    cmd_byte;
  logic          cmd_media_vid_ff;
  logic          cmd_dest_two_ff;
  logic          query_evt;
  logic          cmd_err_evt;
  logic          cmd_route_ok;
  logic          route_chg;
  logic          rep_pend_ff;
  logic          rep_busy_ff;
  logic [2:0]    rep_idx_ff;
  logic          rep_start;
  logic          rep_load;
  logic          rep_done;
  logic [7:0]    rep_char;
  logic [7:0]    fb_byte_ff;
  logic          fb_valid_ff;
  logic [31:0]   rd_mux;

  // ----------------------------------------------------------------
  // front-panel pins
  // ----------------------------------------------------------------
  avrsc_pin_sync #(
    .W (14)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     ({panel_local_btn_i, panel_route_take_i, panel_route_i}),
    .level_o   (pin_level)
  );

  assign panel_routes = avrsc_routes_t'(pin_level[11:0]);
  assign btn_press    = pin_level[13] & ~btn_prev_ff;
  assign take_press   = pin_level[12] & ~take_prev_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      btn_prev_ff  <= 1'b0;
      take_prev_ff <= 1'b0;
    end else begin
      btn_prev_ff  <= pin_level[13];
      take_prev_ff <= pin_level[12];
    end
  end

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, then the access is taken
  // ----------------------------------------------------------------
  assign wr_acc   = avs_write_i & ~avs_waitrequest_o;
  // a read pops at its capture edge, never losing a byte
  assign rd_acc   = avs_read_i & avs_waitrequest_o;
  assign cmd_wr   = wr_acc & (avs_address_i == REG_CMD);
  assign fb_pop   = rd_acc & fb_valid_ff & (avs_address_i == REG_FEEDBACK);
  assign cmd_byte = avs_writedata_i[7:0];

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      REG_CTRL:     rd_mux[CTRL_W-1:0] = ctrl_ff;
      REG_SELECT:   rd_mux[ROUTES_W-1:0] = sel_ff;
      REG_REPORT: begin
        rd_mux[ROUTES_W-1:0]  = routes_ff;
        rd_mux[REPORT_FLAG_B] = local_ff;
      end
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_ff;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
      REG_FEEDBACK: begin
        rd_mux[7:0]        = fb_byte_ff;
        rd_mux[FB_VALID_B] = fb_valid_ff;
      end
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // data stands from the edge that drops waitrequest to the taking edge
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & avs_waitrequest_o) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // control and selection registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_ff     <= avrsc_ctrl_t'(CTRL_RST);
      irq_mask_ff <= MASK_RST;
    end else if (wr_acc) begin
      if (avs_address_i == REG_CTRL) begin
        ctrl_ff <= avrsc_ctrl_t'(avs_writedata_i[CTRL_W-1:0]);
      end
      if (avs_address_i == REG_IRQ_MASK) begin
        irq_mask_ff <= avs_writedata_i[IRQ_W-1:0];
      end
    end
  end

  // (R09) out-of-range codes are refused per field
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sel_ff <= avrsc_routes_t'(ROUTES_RST);
    end else if (wr_acc && (avs_address_i == REG_SELECT)) begin
      sel_ff.vid_one <= pick_src(avs_writedata_i[2:0], sel_ff.vid_one);
      sel_ff.vid_two <= pick_src(avs_writedata_i[5:3], sel_ff.vid_two);
      sel_ff.aud_one <= pick_src(avs_writedata_i[8:6], sel_ff.aud_one);
      sel_ff.aud_two <= pick_src(avs_writedata_i[11:9], sel_ff.aud_two);
    end else if (cmd_route_ok) begin
      // (R13) text route command updates a selection
      case ({cmd_media_vid_ff, cmd_dest_two_ff})
        2'b10:   sel_ff.vid_one <= cmd_byte[2:0];
        2'b11:   sel_ff.vid_two <= cmd_byte[2:0];
        2'b00:   sel_ff.aud_one <= cmd_byte[2:0];
        default: sel_ff.aud_two <= cmd_byte[2:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // text command parser: Q, or V/A then 1/2 then 0-4
  // ----------------------------------------------------------------
  assign query_evt    = cmd_wr && (cmd_st_ff == CMD_IDLE)
                        && (cmd_byte == ASC_QUERY);
  assign cmd_route_ok = cmd_wr && (cmd_st_ff == CMD_DEST)
                        && (cmd_byte >= ASC_ZERO)
                        && (cmd_byte <= src_char(SRC_MAX));

  always_comb begin
    cmd_err_evt = 1'b0;
    if (cmd_wr) begin
      case (cmd_st_ff)
        CMD_IDLE:  cmd_err_evt = (cmd_byte != ASC_QUERY)
                                 && (cmd_byte != ASC_VIDEO)
                                 && (cmd_byte != ASC_AUDIO);
        CMD_MEDIA: cmd_err_evt = (cmd_byte != ASC_ONE)
                                 && (cmd_byte != ASC_TWO);
        CMD_DEST:  cmd_err_evt = ~cmd_route_ok;
        default:   cmd_err_evt = 1'b1;
      endcase
    end
  end

  // (R13) parser walks media, destination, source
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cmd_st_ff        <= CMD_IDLE;
      cmd_media_vid_ff <= 1'b0;
      cmd_dest_two_ff  <= 1'b0;
    end else if (cmd_wr) begin
      case (cmd_st_ff)
        CMD_IDLE: begin
          if ((cmd_byte == ASC_VIDEO) || (cmd_byte == ASC_AUDIO)) begin
            cmd_media_vid_ff <= (cmd_byte == ASC_VIDEO);
            cmd_st_ff        <= CMD_MEDIA;
          end
        end
        CMD_MEDIA: begin
          cmd_dest_two_ff <= (cmd_byte == ASC_TWO);
          cmd_st_ff       <= cmd_err_evt ? CMD_IDLE : CMD_DEST;
        end
        default: begin
          cmd_st_ff <= CMD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // operating mode and active routes
  // ----------------------------------------------------------------
  always_comb begin
    nxt_local = local_ff;
    if (ctrl_ff.panel_local_inhibit) begin
      // (R05) inhibit pulls the unit back to system mode
      // (R03) and keeps the local button from taking effect
      nxt_local = 1'b0;
    end else if (btn_press) begin
      nxt_local = ~local_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      local_ff <= 1'b0;
    end else begin
      local_ff <= nxt_local;
    end
  end

  always_comb begin
    nxt_routes = routes_ff;
    if (local_ff && !ctrl_ff.panel_local_inhibit) begin
      if (take_press) begin
        nxt_routes.vid_one = pick_src(panel_routes.vid_one, routes_ff.vid_one);
        nxt_routes.vid_two = pick_src(panel_routes.vid_two, routes_ff.vid_two);
        nxt_routes.aud_one = pick_src(panel_routes.aud_one, routes_ff.aud_one);
        nxt_routes.aud_two = pick_src(panel_routes.aud_two, routes_ff.aud_two);
      end
    end else begin
      // (R04) outside local mode panel takes never alter routes
      // (R06) system mode follows the selection registers
      // (R18) apply low simply holds the last routes
      if (ctrl_ff.video_route_apply) begin
        // (R01) video gated by its apply bit
        nxt_routes.vid_one = sel_ff.vid_one;
        nxt_routes.vid_two = sel_ff.vid_two;
      end
      if (ctrl_ff.audio_route_apply) begin
        // (R02) audio gated by its apply bit
        nxt_routes.aud_one = sel_ff.aud_one;
        nxt_routes.aud_two = sel_ff.aud_two;
      end
    end
  end

  assign route_chg = (nxt_routes != routes_ff);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      routes_ff <= avrsc_routes_t'(ROUTES_RST);
    end else begin
      routes_ff <= nxt_routes;
    end
  end

  // (R07) (R08) code 0 mutes, 1-4 drive the crosspoint input
  // (R11) (R12) reports carry the active codes as selected
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      video_dest_one_report_o <= ROUTES_RST[2:0];
      video_dest_two_report_o <= ROUTES_RST[5:3];
      audio_dest_one_report_o <= ROUTES_RST[8:6];
      audio_dest_two_report_o <= ROUTES_RST[11:9];
      panel_mode_flag_o       <= 1'b0;
    end else begin
      video_dest_one_report_o <= nxt_routes.vid_one;
      video_dest_two_report_o <= nxt_routes.vid_two;
      audio_dest_one_report_o <= nxt_routes.aud_one;
      audio_dest_two_report_o <= nxt_routes.aud_two;
      // (R10) flag tracks local mode exactly
      panel_mode_flag_o       <= nxt_local;
    end
  end

  // ----------------------------------------------------------------
  // text feedback: V d d A d d CR, one byte per feedback read
  // ----------------------------------------------------------------
  assign rep_start = rep_pend_ff & ~rep_busy_ff;
  assign rep_load  = rep_busy_ff & (~fb_valid_ff | fb_pop);
  assign rep_done  = rep_load & (rep_idx_ff == REP_LAST);

  always_comb begin
    case (rep_idx_ff)
      3'h0:    rep_char = ASC_VIDEO;
      3'h1:    rep_char = src_char(rep_snap_ff.vid_one);
      3'h2:    rep_char = src_char(rep_snap_ff.vid_two);
      3'h3:    rep_char = ASC_AUDIO;
      3'h4:    rep_char = src_char(rep_snap_ff.aud_one);
      3'h5:    rep_char = src_char(rep_snap_ff.aud_two);
      default: rep_char = ASC_CR;
    endcase
  end

  // a trigger while a report runs is kept, so no change goes unreported
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rep_pend_ff <= 1'b0;
    end else if (query_evt || (ctrl_ff.verbose && route_chg)) begin
      // (R14) verbose change report, (R15) query report
      rep_pend_ff <= 1'b1;
    end else if (rep_start) begin
      rep_pend_ff <= 1'b0;
    end
  end

  // (R15) snapshot keeps the whole state consistent in one report
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rep_busy_ff <= 1'b0;
      rep_idx_ff  <= 3'h0;
      rep_snap_ff <= avrsc_routes_t'(ROUTES_RST);
    end else if (rep_start) begin
      rep_busy_ff <= 1'b1;
      rep_idx_ff  <= 3'h0;
      rep_snap_ff <= routes_ff;
    end else if (rep_load) begin
      rep_busy_ff <= ~rep_done;
      rep_idx_ff  <= rep_idx_ff + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      fb_byte_ff  <= 8'h00;
      fb_valid_ff <= 1'b0;
    end else if (rep_load) begin
      fb_byte_ff  <= rep_char;
      fb_valid_ff <= 1'b1;
    end else if (fb_pop) begin
      fb_valid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  always_comb begin
    irq_evt                = '0;
    irq_evt[IRQ_ROUTE_B]   = route_chg;
    irq_evt[IRQ_MODE_B]    = nxt_local ^ local_ff;
    irq_evt[IRQ_CMDERR_B]  = cmd_err_evt;
    irq_evt[IRQ_REPDONE_B] = rep_done;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      irq_stat_ff <= '0;
    end else if (wr_acc && (avs_address_i == REG_IRQ_STAT)) begin
      irq_stat_ff <= (irq_stat_ff & ~avs_writedata_i[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_evt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

endmodule
`default_nettype wire

// file: hdl/avrsc_pkg.sv
// package: register map, field layout, reset values and types of the route control
package avrsc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_SELECT   = 8'h04;
  localparam logic [7:0] REG_REPORT   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_CMD      = 8'h14;
  localparam logic [7:0] REG_FEEDBACK = 8'h18;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int CTRL_W        = 4;
  localparam int ROUTES_W      = 12;
  localparam int IRQ_W         = 4;
  localparam int REPORT_FLAG_B = 16;
  localparam int FB_VALID_B    = 8;
  localparam int IRQ_ROUTE_B   = 0;
  localparam int IRQ_MODE_B    = 1;
  localparam int IRQ_CMDERR_B  = 2;
  localparam int IRQ_REPDONE_B = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTRL_RST   = 4'h3;
  localparam logic [11:0] ROUTES_RST = 12'h000;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  // ----------------------------------------------------------------
  // source codes and text protocol characters
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_MAX   = 3'h4;
  localparam logic [7:0] ASC_QUERY = 8'h51;
  localparam logic [7:0] ASC_VIDEO = 8'h56;
  localparam logic [7:0] ASC_AUDIO = 8'h41;
  localparam logic [7:0] ASC_ZERO  = 8'h30;
  localparam logic [7:0] ASC_ONE   = 8'h31;
  localparam logic [7:0] ASC_TWO   = 8'h32;
  localparam logic [7:0] ASC_CR    = 8'h0D;
  localparam logic [2:0] REP_LAST  = 3'h6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] aud_two;
    logic [2:0] aud_one;
    logic [2:0] vid_two;
    logic [2:0] vid_one;
  } avrsc_routes_t;

  typedef struct packed {
    logic verbose;
    logic panel_local_inhibit;
    logic audio_route_apply;
    logic video_route_apply;
  } avrsc_ctrl_t;

  typedef enum logic [1:0] {
    CMD_IDLE  = 2'b00,
    CMD_MEDIA = 2'b01,
    CMD_DEST  = 2'b10
  } avrsc_cmd_st_t;

endpackage

// file: hdl/avrsc_pin_sync.sv
// three-stage synchroniser for front-panel pins with agreement filter
`timescale 1ns/1ps
`default_nettype none
module avrsc_pin_sync #(
  parameter int W = 14
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync2_ff;
  logic [W-1:0] sync3_ff;
  logic [W-1:0] agree;

  // a bit only moves once stages two and three show the same value
  assign agree = sync2_ff ~^ sync3_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      meta_ff  <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      meta_ff  <= pin_i;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      level_o <= '0;
    end else begin
      level_o <= (agree & sync3_ff) | (~agree & level_o);
    end
  end

endmodule
`default_nettype wire

// file: dv/avrsc_ctrl_sys_model.sv
// control system model: avalon-mm master for the route control
`timescale 1ns/1ps
`default_nettype none
module avrsc_ctrl_sys_model (
  input  wire logic        ref_clk_i,
  input  wire logic        wait_i,
  input  wire logic [31:0] rdata_i,
  output logic      [7:0]  adr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] wd_o
);
  logic hung = 1'b0;
  initial begin
    adr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wd_o = 32'h0;
  end
  // one word per access; address picks the register offset
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr_o <= a;
    wd_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge ref_clk_i);
    while (wait_i !== 1'b0 && n < 64) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 64) hung = 1'b1;
    q = rdata_i;
    // released lines carry junk
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    adr_o <= ~a;
    wd_o <= ~d;
    @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// file: dv/avrsc_route_ctrl_assertions.sv
// port-level checks of the route control
`timescale 1ns/1ps
`default_nettype none
module avrsc_route_ctrl_assertions
  import avrsc_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        panel_mode_flag_o,
  input wire logic [2:0]  video_dest_one_report_o,
  input wire logic [2:0]  video_dest_two_report_o,
  input wire logic [2:0]  audio_dest_one_report_o,
  input wire logic [2:0]  audio_dest_two_report_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic        bus_wr;
  logic [3:0]  ctrl_ff;
  logic [11:0] sel_ff;
  assign bus_wr = avs_write_i && !avs_waitrequest_o;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_ff <= CTRL_RST;
      sel_ff  <= ROUTES_RST;
    end else if (bus_wr && avs_address_i == REG_CTRL) begin
      ctrl_ff <= avs_writedata_i[3:0];
    end else if (bus_wr && avs_address_i == REG_SELECT) begin
      sel_ff <= avs_writedata_i[11:0];
    end
  end
  a_wait_one:
  assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("late answer");
  a_wait_pulse:
  assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
  a_unmapped_zero:
  assert property (avs_read_i && avs_waitrequest_o
    && avs_address_i > REG_FEEDBACK |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_sel_video:
  assert property (bus_wr && avs_address_i == REG_SELECT && ctrl_ff[0]
    && !panel_mode_flag_o && avs_writedata_i[2:0] <= SRC_MAX
    |-> ##2 video_dest_one_report_o == sel_ff[2:0])
    else $error("video not applied");
  a_sel_audio:
  assert property (bus_wr && avs_address_i == REG_SELECT && ctrl_ff[1]
    && !panel_mode_flag_o && avs_writedata_i[8:6] <= SRC_MAX
    |-> ##2 audio_dest_one_report_o == sel_ff[8:6])
    else $error("audio not applied");
  a_hold_video:
  assert property ((!ctrl_ff[0] && !panel_mode_flag_o) [*2]
    |=> $stable(video_dest_one_report_o)
    && $stable(video_dest_two_report_o)) else $error("video not held");
  a_inhibit_local:
  assert property (ctrl_ff[2] ##1 ctrl_ff[2] |-> !panel_mode_flag_o)
    else $error("local mode under inhibit");
  a_src_range:
  assert property (video_dest_one_report_o <= SRC_MAX
    && video_dest_two_report_o <= SRC_MAX
    && audio_dest_one_report_o <= SRC_MAX
    && audio_dest_two_report_o <= SRC_MAX) else $error("bad route code");
  c_local: cover property ($rose(panel_mode_flag_o));
  c_text: cover property (bus_wr && avs_address_i == REG_CMD);
  c_hold: cover property (!ctrl_ff[0] && !ctrl_ff[1]);
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// top bench: control system model, panel pins and checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import avrsc_pkg::*;
  logic          ref_clk_i = 1'b0;
  logic          resetn_i  = 1'b0;
  logic [1:0]    pins      = 2'b00;
  logic [11:0]   pnl       = 12'h000;
  logic [7:0]    adr;
  logic          rd, wr, wreq, irq, flag;
  logic [31:0]   wd, rdat, q;
  logic [2:0]    v1, v2, a1, a2;
  logic [31:0]   cv [4] = '{32'h2, 32'h1, 32'h0, 32'h3};
  avrsc_routes_t exp_r = '0;
  avrsc_routes_t sel = '0;
  logic [11:0]   nr;
  int            mismatches = 0;
  int            num_checks = 0;
  int            seed = 26193;
  always #2 ref_clk_i = ~ref_clk_i;
  avrsc_ctrl_sys_model i_host (.ref_clk_i(ref_clk_i), .wait_i(wreq),
    .rdata_i(rdat), .adr_o(adr), .rd_o(rd), .wr_o(wr), .wd_o(wd));
  avrsc_route_ctrl i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .irq_o(irq), .panel_local_btn_i(pins[0]), .panel_route_take_i(pins[1]),
    .panel_route_i(pnl), .panel_mode_flag_o(flag),
    .video_dest_one_report_o(v1), .video_dest_two_report_o(v2),
    .audio_dest_one_report_o(a1), .audio_dest_two_report_o(a2));
  function automatic logic [2:0] pick(logic [2:0] o, logic [2:0] n);
    return (n > SRC_MAX) ? o : n;
  endfunction
  function automatic avrsc_routes_t merge(avrsc_routes_t o, logic [11:0] n);
    return {pick(o.aud_two, n[11:9]), pick(o.aud_one, n[8:6]),
            pick(o.vid_two, n[5:3]), pick(o.vid_one, n[2:0])};
  endfunction
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
    i_host.xfer(we, a, d, q);
    if (i_host.hung) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic routes_chk();
    @(posedge ref_clk_i);
    chk("reports", {20'h0, exp_r}, {20'h0, a2, a1, v2, v1});
    bus(1'b0, REG_REPORT, 32'h0);
    chk("report_reg", {15'h0, flag, 4'h0, exp_r}, q);
  endtask
  task automatic press(int b);
    pins[b] <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    pins[b] <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic fb_chk();
    logic [7:0] e [7];
    int n;
    e = '{ASC_VIDEO, ASC_ZERO + exp_r.vid_one, ASC_ZERO + exp_r.vid_two,
          ASC_AUDIO, ASC_ZERO + exp_r.aud_one, ASC_ZERO + exp_r.aud_two,
          ASC_CR};
    foreach (e[i]) begin
      n = 0;
      do begin
        bus(1'b0, REG_FEEDBACK, 32'h0);
        n++;
      end while (q[FB_VALID_B] !== 1'b1 && n < 40);
      if (q[FB_VALID_B] !== 1'b1) begin
        mismatches++;
        summarize();
      end
      chk("feedback", {24'h0, e[i]}, {24'h0, q[7:0]});
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk("idle", 32'h4, {29'h0, wreq, irq, flag});
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b1, REG_REPORT, 32'h0000_0FFF);
    routes_chk();
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", {28'h0, CTRL_RST}, q);
    bus(1'b0, REG_IRQ_MASK, 32'h0);
    chk("mask", {28'h0, MASK_RST}, q);
    bus(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, q);
    // irq: masked, unmasked, cleared
    bus(1'b1, REG_SELECT, 32'h001);
    sel = merge(sel, 12'h001);
    exp_r = sel;
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk("stat_route", 32'h1, {31'h0, q[IRQ_ROUTE_B]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    @(posedge ref_clk_i);
    chk("irq_on", 32'h1, {31'h0, irq});
    bus(1'b1, REG_IRQ_STAT, 32'h1);
    @(posedge ref_clk_i);
    chk("irq_off", 32'h0, {31'h0, irq});
    // random selections, codes over four refused
    repeat (12) begin
      nr = 12'($random(seed));
      bus(1'b1, REG_SELECT, {20'h0, nr});
      sel = merge(sel, nr);
      exp_r = sel;
      routes_chk();
    end
    // apply bit combinations
    foreach (cv[k]) begin
      bus(1'b1, REG_CTRL, cv[k]);
      nr = 12'($random(seed));
      bus(1'b1, REG_SELECT, {20'h0, nr});
      sel = merge(sel, nr);
      if (cv[k][0]) {exp_r.vid_two, exp_r.vid_one} = {sel.vid_two, sel.vid_one};
      if (cv[k][1]) {exp_r.aud_two, exp_r.aud_one} = {sel.aud_two, sel.aud_one};
      routes_chk();
    end
    bus(1'b1, REG_CMD, {24'h0, ASC_VIDEO});
    bus(1'b1, REG_CMD, {24'h0, ASC_TWO});
    bus(1'b1, REG_CMD, {24'h0, ASC_ZERO + 8'h03});
    sel.vid_two = 3'h3;
    exp_r = sel;
    routes_chk();
    bus(1'b1, REG_CMD, 32'h7A);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk("stat_cmd", 32'h1, {31'h0, q[IRQ_CMDERR_B]});
    bus(1'b1, REG_CMD, {24'h0, ASC_QUERY});
    fb_chk();
    bus(1'b1, REG_CTRL, 32'hB);
    bus(1'b1, REG_SELECT, 32'h0A4);
    sel = merge(sel, 12'h0A4);
    exp_r = sel;
    fb_chk();
    bus(1'b1, REG_CTRL, 32'h3);
    // local mode, take, then inhibit
    press(0);
    chk("flag", 32'h1, {31'h0, flag});
    pnl <= 12'h8D1;
    press(1);
    exp_r = 12'h8D1;
    routes_chk();
    bus(1'b1, REG_CTRL, 32'h7);
    @(posedge ref_clk_i);
    chk("flag", 32'h0, {31'h0, flag});
    exp_r = sel;
    routes_chk();
    press(0);
    chk("flag", 32'h0, {31'h0, flag});
    pnl <= 12'h44A;
    press(1);
    routes_chk();
    bus(1'b1, REG_CTRL, 32'h3);
    press(0);
    chk("flag", 32'h1, {31'h0, flag});
    press(0);
    chk("flag", 32'h0, {31'h0, flag});
    summarize();
  end
endmodule
bind avrsc_route_ctrl avrsc_route_ctrl_assertions i_chk (.ref_clk_i,
  .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .panel_mode_flag_o,
  .video_dest_one_report_o, .video_dest_two_report_o,
  .audio_dest_one_report_o, .audio_dest_two_report_o);
`default_nettype wire
